// ==== bench/config_password_key_store_bench.sv ====
/*
  Self-checking bench for the key store with a short refresh count.
  Assumes the checker binds itself to the device.
*/
`timescale 1ns/1ps
module config_password_key_store_bench import cpk_pkg::*;;
  localparam int N = 20;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] en = 8'h00;
  logic [31:0] entry = 32'h0;
  logic wr;
  logic rd;
  logic cmd_wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] code;
  logic [7:0] loc;
  logic [7:0] sbyte;
  logic [7:0] rdata;
  logic rvalid, active, unlocked, done, v;
  logic [7:0] d;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  cpk_host host (.i_sys_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata), .o_cmd(cmd_wr), .o_code(code), .o_loc(loc),
    .o_byte(sbyte));
  cpk_key_store #(.REFRESH_CYCLES(N)) dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_cmd_wr(cmd_wr), .i_cmd_code(code), .i_staged_storage_location(loc),
    .i_staged_storage_byte(sbyte), .i_protection_enable_byte(en),
    .i_entry_password(entry), .o_protection_active(active), .o_config_unlocked(unlocked),
    .o_refresh_done(done));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic probe(input logic [7:0] e, input logic [31:0] p, input logic exp);
    en = e;
    entry = p;
    repeat (2) @(posedge clk);
    #1 check("unlocked", unlocked, exp);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      print_verdict;
    end
  end
  // Reset for five edges, then the power-up refresh count; also run in mid-test.
  task automatic test_powerup;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    check("active", active, 1'b0);
    check("unlocked", unlocked, 1'b1);
    check("done", done, 1'b0);
    repeat (N - 1) @(posedge clk);
    #1 check("done", done, 1'b0);
    @(posedge clk);
    #1 check("done", done, 1'b1);
  endtask
  task automatic test_delivered;
    probe(8'hFF, 32'h0, 1'b1);
    check("active", active, 1'b1);
    probe(8'hFF, 32'h1, 1'b0);
    probe(8'hFE, 32'h1, 1'b1);
  endtask
  task automatic test_key_bytes;
    for (int i = 0; i < CPK_KEY_BYTES; i++)
    begin
      host.wr(CPK_ADDR_KEY_BYTE_LOW + 8'(i), 8'(8'h11 * (i + 1)));
    end
    probe(8'hFF, 32'h44332211, 1'b1);
    for (int i = 0; i < CPK_KEY_BYTES; i++)
    begin
      probe(8'hFF, 32'h44332211 ^ (32'h1 << (8 * i)), 1'b0);
    end
  endtask
  // The last mismatch above leaves the store locked, so this write must be lost.
  task automatic test_write_only;
    host.wr(CPK_ADDR_KEY_BYTE_LOW, 8'h00);
    probe(8'hFF, 32'h44332211, 1'b1);
    host.rd(CPK_ADDR_KEY_BYTE_HIGH, v, d);
    check("rvalid", v, 1'b1);
    check("rdata", d, CPK_READ_HIDDEN);
  endtask
  task automatic test_store_refresh;
    host.cmd(CPK_CMD_STORE_BYTE, CPK_ADDR_KEY_BYTE_SECOND, 8'h5C);
    host.cmd(CPK_CMD_REFRESH_ALL, 8'h00, 8'h00);
    probe(8'hFF, 32'h00005C00, 1'b1);
    probe(8'hFF, 32'h44332211, 1'b0);
    host.cmd(CPK_CMD_STORE_BYTE, CPK_ADDR_KEY_BYTE_LOW, 8'h77);
    host.cmd(CPK_CMD_REFRESH_ALL, 8'h00, 8'h00);
    probe(8'hFF, 32'h00005C00, 1'b1);
    host.cmd(CPK_CMD_STORE_BYTE, 8'h35, 8'hAA);
    host.cmd(CPK_CMD_REFRESH_ALL, 8'h00, 8'h00);
    probe(8'hFF, 32'h00005C00, 1'b1);
  endtask
  // Reset stands for the delivered state, so the stored key is zero again.
  task automatic test_after_reset;
    probe(8'hFF, 32'h0, 1'b1);
    probe(8'hFF, 32'h00005C00, 1'b0);
  endtask
  initial
  begin
    test_powerup();
    test_delivered();
    test_key_bytes();
    test_write_only();
    test_store_refresh();
    test_powerup();
    test_after_reset();
    print_verdict;
  end
endmodule

// ==== bench/cpk_host.sv ====
/*
  Host side model: issues decoded byte accesses and storage commands.
  Assumes callers are parked just after a rising clock edge.
*/
`timescale 1ns/1ps
module cpk_host
(
  // Clock and the device's read answer
  input wire logic i_sys_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  // Register bus requests
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00,
  // Storage command requests
  output logic o_cmd = 1'b0,
  output logic [7:0] o_code = 8'h00,
  output logic [7:0] o_loc = 8'h00,
  output logic [7:0] o_byte = 8'h00
);
  // The device takes a strobe at one edge with no handshake, so each
  // request stands for exactly one rising edge and is then withdrawn.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1 {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(posedge i_sys_clk);
    #1 {o_wr, o_wdata} = {1'b0, ~d};
  endtask
  // The answer is launched at the edge that takes the read and stands
  // for one cycle, so it is picked up just after that edge.
  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1 {o_rd, o_addr} = {1'b1, a};
    @(posedge i_sys_clk);
    #1 o_rd = 1'b0;
    v = i_rvalid;
    d = i_rdata;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] l, input logic [7:0] b);
    @(posedge i_sys_clk);
    #1 {o_cmd, o_code, o_loc, o_byte} = {1'b1, c, l, b};
    @(posedge i_sys_clk);
    #1 {o_cmd, o_byte} = {1'b0, ~b};
  endtask
endmodule

// ==== bench/cpk_key_store_chk.sv ====
/*
  Port-level checker for the key store.
  Bound to every cpk_key_store instance; sees only the top ports.
*/
`timescale 1ns/1ps
module cpk_key_store_chk
  import cpk_pkg::*;
#(
  parameter int REFRESH_CYCLES = CPK_REFRESH_CYCLES
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register and command side
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_staged_storage_location,
  input wire logic [7:0] i_staged_storage_byte,
  // Password side and status
  input wire logic [7:0] i_protection_enable_byte,
  input wire logic [31:0] i_entry_password,
  input wire logic o_protection_active,
  input wire logic o_config_unlocked,
  input wire logic o_refresh_done
);
  // Edges since reset release, saturating so it cannot wrap in long runs.
  int unsigned up_cnt;
  always_ff @(posedge i_sys_clk)
    if (!i_rst_n) up_cnt <= 0;
    else if (up_cnt < REFRESH_CYCLES) up_cnt <= up_cnt + 1;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_read_answers: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  chk_no_spurious_valid: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("rvalid without read");
  chk_read_hidden: assert property (o_reg_rdata == CPK_READ_HIDDEN)
    else $error("key byte revealed");
  chk_active_follows: assert property (i_rst_n |=>
    o_protection_active == ($past(i_protection_enable_byte) == CPK_PROTECT_ON))
    else $error("active flag wrong");
  chk_off_unlocks: assert property ((i_protection_enable_byte != CPK_PROTECT_ON)
    |=> o_config_unlocked)
    else $error("locked while protection off");
  chk_inactive_open: assert property (!o_protection_active |-> o_config_unlocked)
    else $error("locked while inactive");
  chk_done_sticky: assert property (o_refresh_done |=> o_refresh_done)
    else $error("refresh done dropped");
  chk_done_timing: assert property (o_refresh_done == (up_cnt >= REFRESH_CYCLES))
    else $error("refresh done at wrong cycle");
endmodule

bind cpk_key_store cpk_key_store_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.*);

// ==== rtl/cpk_key_store.sv ====
/*
  Configuration password key store: four write-only key bytes mirrored
  in RAM and backed by a nonvolatile copy, with power-up reload, refresh
  and store commands, and the password comparison that unlocks writes.
  Assumes the serial bus front end delivers decoded byte accesses on the
  system clock, and that the enable and entry bytes come from the
  neighbouring password registers on the same clock.
*/
// Functional notes
// R1: About 66 ms after power-up the first refresh loads all four key bytes from storage.
// R2: Every key byte is delivered as zero, so the delivered key is all zeros.
// R3: Address 31h holds key bits 7 to 0 and accepts any byte value.
// R4: Address 32h holds key bits 15 to 8 and accepts any byte value.
// R5: Address 33h holds key bits 23 to 16 and accepts any byte value.
// R6: Address 34h holds key bits 31 to 24 and accepts any byte value.
// R7: The key bytes read back as zero and their writes are blocked while locked.
// R8: Protection is active only when the enable byte is 255, and then the entry bytes carry a password.
// R9: Command 12h copies all stored key bytes into their RAM mirror.
// R10: Command 21h stores the staged byte into the stored key byte at the staged location.
// R11: While protection is active, writes are allowed only once the entry value equals the key.
`timescale 1ns/1ps
module cpk_key_store
  import cpk_pkg::*;
#(
  parameter int REFRESH_CYCLES = CPK_REFRESH_CYCLES
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Decoded register accesses from the serial bus front end
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Storage command engine
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_staged_storage_location,
  input wire logic [7:0] i_staged_storage_byte,
  // Password registers next door
  input wire logic [7:0] i_protection_enable_byte,
  input wire logic [31:0] i_entry_password,
  // Status
  output logic o_protection_active,
  output logic o_config_unlocked,
  output logic o_refresh_done
);

  localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  cpk_state_t state_reg;
  cpk_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [7:0] key_mirror_reg [CPK_KEY_BYTES];
  logic [7:0] key_nv_reg [CPK_KEY_BYTES];
  logic [7:0] reg_rdata_reg;
  logic reg_rvalid_reg;
  logic protection_active_reg;
  logic config_unlocked_reg;
  logic refresh_done_reg;

  // Address decode for bus writes and staged stores.
  wire logic bus_hits_key;
  wire logic [1:0] bus_key_idx;
  wire logic stage_hits_key;
  wire logic [1:0] stage_key_idx;
  wire logic [7:0] bus_offset;
  wire logic [7:0] stage_offset;
  wire logic key_write;
  wire logic key_store;
  wire logic cmd_refresh;
  wire logic powerup_refresh;
  wire logic do_refresh;
  wire logic [31:0] key_value;
  wire logic protect_on_next;
  wire logic unlocked_next;

  assign bus_offset = i_reg_addr - CPK_ADDR_KEY_BYTE_LOW;
  assign stage_offset = i_staged_storage_location - CPK_ADDR_KEY_BYTE_LOW;
  assign bus_hits_key = (i_reg_addr >= CPK_ADDR_KEY_BYTE_LOW)
    && (i_reg_addr <= CPK_ADDR_KEY_BYTE_HIGH);
  assign stage_hits_key = (i_staged_storage_location >= CPK_ADDR_KEY_BYTE_LOW)
    && (i_staged_storage_location <= CPK_ADDR_KEY_BYTE_HIGH);
  assign bus_key_idx = bus_offset[1:0];
  assign stage_key_idx = stage_offset[1:0];

  // Writes to any key byte are refused unless the store is unlocked.
  assign key_write = i_reg_wr && bus_hits_key && config_unlocked_reg; // R7
  // Storing a key byte through the command engine obeys the same lock.
  assign key_store = i_cmd_wr && (i_cmd_code == CPK_CMD_STORE_BYTE)
    && stage_hits_key && config_unlocked_reg; // R10
  assign cmd_refresh = i_cmd_wr && (i_cmd_code == CPK_CMD_REFRESH_ALL); // R9
  assign powerup_refresh = (state_reg == CPK_ST_WAIT_REFRESH) && (cnt_reg == CNT_LAST); // R1
  assign do_refresh = cmd_refresh || powerup_refresh;

  // Key assembled high byte first, so the byte at 31h is bits 7 to 0.
  assign key_value = {key_mirror_reg[3], key_mirror_reg[2],
    key_mirror_reg[1], key_mirror_reg[0]}; // R3 R4 R5 R6

  assign protect_on_next = (i_protection_enable_byte == CPK_PROTECT_ON); // R8
  // A match with the key taken from the mirror is what opens the store.
  assign unlocked_next = !protect_on_next || (i_entry_password == key_value); // R11

  // Power-up sequencer: wait out the first refresh, then run.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      CPK_ST_WAIT_REFRESH:
      begin
        if (powerup_refresh)
        begin
          state_next = CPK_ST_RUN;
        end
        else
        begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end
      CPK_ST_RUN:
      begin
        cnt_next = cnt_reg;
      end
      default:
      begin
        state_next = CPK_ST_WAIT_REFRESH;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= CPK_ST_WAIT_REFRESH;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Reset stands for the delivered state of the stored copy, so it also
  // clears the nonvolatile bytes; a real part keeps them across power.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < CPK_KEY_BYTES; i++)
      begin
        key_nv_reg[i] <= CPK_KEY_DELIVERED; // R2
      end
    end
    else if (key_store)
    begin
      key_nv_reg[stage_key_idx] <= i_staged_storage_byte; // R10
    end
  end

  // A refresh overrides a bus write in the same cycle, since the stored
  // copy is the authority once a reload has been asked for.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < CPK_KEY_BYTES; i++)
      begin
        key_mirror_reg[i] <= CPK_KEY_DELIVERED; // R2
      end
    end
    else if (do_refresh)
    begin
      for (int i = 0; i < CPK_KEY_BYTES; i++)
      begin
        key_mirror_reg[i] <= key_nv_reg[i]; // R1 R9
      end
    end
    else if (key_write)
    begin
      key_mirror_reg[bus_key_idx] <= i_reg_wdata; // R3 R4 R5 R6
    end
  end

  // Reads never expose the key; every read is answered one cycle later.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      reg_rdata_reg <= CPK_READ_HIDDEN;
      reg_rvalid_reg <= 1'b0;
    end
    else
    begin
      reg_rdata_reg <= CPK_READ_HIDDEN; // R7
      reg_rvalid_reg <= i_reg_rd;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      protection_active_reg <= 1'b0;
      config_unlocked_reg <= 1'b1;
      refresh_done_reg <= 1'b0;
    end
    else
    begin
      protection_active_reg <= protect_on_next; // R8
      config_unlocked_reg <= unlocked_next; // R11
      refresh_done_reg <= refresh_done_reg || powerup_refresh; // R1
    end
  end

  assign o_reg_rdata = reg_rdata_reg;
  assign o_reg_rvalid = reg_rvalid_reg;
  assign o_protection_active = protection_active_reg;
  assign o_config_unlocked = config_unlocked_reg;
  assign o_refresh_done = refresh_done_reg;

endmodule

// ==== rtl/cpk_pkg.sv ====
/*
  Shared constants for the configuration password key store: register
  offsets, storage command codes, reset values and refresh timing.
  Assumes a single 100 MHz system clock and byte-wide register access.
*/
package cpk_pkg;

  // Register offsets of the four key bytes, low byte first.
  localparam logic [7:0] CPK_ADDR_KEY_BYTE_LOW = 8'h31;
  localparam logic [7:0] CPK_ADDR_KEY_BYTE_SECOND = 8'h32;
  localparam logic [7:0] CPK_ADDR_KEY_BYTE_THIRD = 8'h33;
  localparam logic [7:0] CPK_ADDR_KEY_BYTE_HIGH = 8'h34;

  // Storage command codes seen on the command register.
  localparam logic [7:0] CPK_CMD_REFRESH_ALL = 8'h12;
  localparam logic [7:0] CPK_CMD_STORE_BYTE = 8'h21;

  // Protection enable value that turns the password function on.
  localparam logic [7:0] CPK_PROTECT_ON = 8'hFF;

  // Delivered value of every key byte and the value that reads return.
  localparam logic [7:0] CPK_KEY_DELIVERED = 8'h00;
  localparam logic [7:0] CPK_READ_HIDDEN = 8'h00;

  // Number of key bytes and the byte width.
  localparam int CPK_KEY_BYTES = 4;
  localparam int CPK_BYTE_W = 8;

  // Power-up refresh delay and the clock rate it is counted against.
  localparam int CPK_REFRESH_TIME_MS = 66;
  localparam int CPK_CLK_HZ = 100000000;
  localparam int CPK_REFRESH_CYCLES = CPK_REFRESH_TIME_MS * (CPK_CLK_HZ / 1000);

  // Power-up sequencing states.
  typedef enum logic [1:0] {
    CPK_ST_WAIT_REFRESH = 2'b01,
    CPK_ST_RUN = 2'b10
  } cpk_state_t;

endpackage
